// ---- design/dio_cond_regs.vh ----
// register map, field positions, reset values and timing counts for dio_cond
// assumes a 32-bit apb slave; all offsets are byte addresses
`ifndef DIO_COND_REGS_VH
`define DIO_COND_REGS_VH

`define CTRL_OFF        12'h000
`define FILT_EN_OFF     12'h004
`define FILT_HALF_OFF   12'h008
`define RISE_EN_OFF     12'h00c
`define FALL_EN_OFF     12'h010
`define STATUS_OFF      12'h014
`define DIN_OFF         12'h018
`define DOUT_OFF        12'h01c
`define POWERUP_OFF     12'h020
`define SAFE_OFF        12'h024
`define WD_TIMEOUT_OFF  12'h028
`define CMD_OFF         12'h02c

`define CTRL_WD_ARM     0
`define CMD_REFRESH     0
`define CMD_SERVICE     1
`define ST_CHANGE       0
`define ST_OVERFLOW     1
`define ST_WD_EXPIRED   2

`define POWERUP_RST     8'h00
`define FILT_HALF_RST   32'h00000002
`define WD_TIMEOUT_RST  32'hffffffff

`define SAMPLE_PERIOD_NS 40000
`define CLK_PERIOD_NS    20
`define SAMPLE_CYCLES    (`SAMPLE_PERIOD_NS / `CLK_PERIOD_NS)

`endif

// ---- design/dio_cond.v ----
// digital input filter, change detection, power-up outputs and watchdog
// assumes an apb master on pclk and inputs synchronous to pclk
`timescale 1ns/100ps
`default_nettype none
`include "dio_cond_regs.vh"

module dio_cond #(
   parameter        N          = 8,
   parameter [15:0] TICK_COUNT = `SAMPLE_CYCLES
) (
   input  wire         pclk,
   input  wire         presetn,
   input  wire         psel,
   input  wire         penable,
   input  wire         pwrite,
   input  wire [11:0]  paddr,
   input  wire [31:0]  pwdata,
   output reg  [31:0]  prdata,
   output reg          pready,
   output reg          pslverr,
   input  wire [N-1:0] din,
   output reg  [N-1:0] dout,
   output reg          change_irq,
   output reg          wd_expired
);

   reg  [15:0]  tick_cnt;
   reg          tick;
   reg  [N-1:0] sampled;
   reg  [31:0]  fclk_cnt;
   reg          fclk_edge;
   wire [N-1:0] filt;

   reg  [N-1:0] filt_q;
   reg  [N-1:0] filt_en;
   reg  [31:0]  filt_half;
   reg  [N-1:0] rise_en;
   reg  [N-1:0] fall_en;
   reg          overflow;
   reg  [N-1:0] din_shown;

   reg  [N-1:0] powerup;
   reg  [N-1:0] safe_val;
   reg  [31:0]  wd_timeout;
   reg  [31:0]  wd_cnt;
   reg          wd_arm;
   reg  [N-1:0] next_dout;
   reg          pwr_loaded;
   reg  [31:0]  rdata;

   wire         acc;
   wire         wr;
   wire         rd;
   wire         wr_ctrl;
   wire         wr_filt_en;
   wire         wr_filt_half;
   wire         wr_rise;
   wire         wr_fall;
   wire         wr_dout;
   wire         wr_pwr;
   wire         wr_safe;
   wire         wr_tmo;
   wire         wr_cmd;

   wire [N-1:0] line;
   wire [N-1:0] edge_hit;
   wire [N-1:0] watch;
   wire         any_edge;
   wire         refresh;
   wire         service;
   wire         disarm;

   function hit;
      input [11:0] a;
      input [11:0] off;
      begin
         hit = (a == off);
      end
   endfunction

   assign acc      = psel & penable;
   assign wr       = acc & pwrite;
   assign rd       = acc & ~pwrite;

   // register write strobes
   assign wr_ctrl      = wr & hit(paddr, `CTRL_OFF);
   assign wr_filt_en   = wr & hit(paddr, `FILT_EN_OFF);
   assign wr_filt_half = wr & hit(paddr, `FILT_HALF_OFF);
   assign wr_rise      = wr & hit(paddr, `RISE_EN_OFF);
   assign wr_fall      = wr & hit(paddr, `FALL_EN_OFF);
   assign wr_dout      = wr & hit(paddr, `DOUT_OFF);
   assign wr_pwr       = wr & hit(paddr, `POWERUP_OFF);
   assign wr_safe      = wr & hit(paddr, `SAFE_OFF);
   assign wr_tmo       = wr & hit(paddr, `WD_TIMEOUT_OFF);
   assign wr_cmd       = wr & hit(paddr, `CMD_OFF);

   assign line     = (filt_en & filt) | (~filt_en & sampled);
   assign edge_hit = (rise_en & line & ~filt_q) | (fall_en & ~line & filt_q);
   assign any_edge = |edge_hit;
   assign watch    = rise_en | fall_en;
   assign refresh  = wr_cmd & pwdata[`CMD_REFRESH];
   assign service  = wr_cmd & pwdata[`CMD_SERVICE];
   assign disarm   = wr_ctrl & ~pwdata[`CTRL_WD_ARM];

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt <= 16'h0000;
         tick     <= 1'b0;
         sampled  <= {N{1'b0}};
      end else begin
         tick <= 1'b0;
         if (tick_cnt >= TICK_COUNT - 16'h0001) begin
            tick_cnt <= 16'h0000;
            tick     <= 1'b1;
            sampled  <= din;
         end else begin
            tick_cnt <= tick_cnt + 16'h0001;
         end
      end
   end

   // filter clock, half interval in ticks
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fclk_cnt  <= 32'h00000000;
         fclk_edge <= 1'b0;
      end else begin
         fclk_edge <= 1'b0;
         if (tick) begin
            if (fclk_cnt >= filt_half - 32'h00000001) begin
               fclk_cnt  <= 32'h00000000;
               fclk_edge <= 1'b1;
            end else begin
               fclk_cnt <= fclk_cnt + 32'h00000001;
            end
         end
      end
   end

   // two stable filter edges per line
   genvar g;
   generate
      for (g = 0; g < N; g = g + 1) begin : flt
         reg cand_b;
         reg filt_b;
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               cand_b <= 1'b0;
               filt_b <= 1'b0;
            end else if (fclk_edge) begin
               cand_b <= sampled[g];
               if (sampled[g] == cand_b) begin
                  filt_b <= sampled[g];
               end
            end
         end
         assign filt[g] = filt_b;
      end
   endgenerate

   // change detection and hidden input view
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         filt_q     <= {N{1'b0}};
         change_irq <= 1'b0;
         overflow   <= 1'b0;
         din_shown  <= {N{1'b0}};
      end else begin
         filt_q <= line;

         if (any_edge) begin
            change_irq <= 1'b1;
         end else if (service) begin
            change_irq <= 1'b0;
         end
         if (any_edge && change_irq && !service) begin
            overflow <= 1'b1;
         end else if (service) begin
            overflow <= 1'b0;
         end

         din_shown <= (line & ~watch) | (din_shown & watch);
         if (any_edge) begin
            din_shown <= line;
         end
      end
   end

   always @* begin
      next_dout = dout;
      if (wd_expired) begin
         next_dout = safe_val;
      end else if (wr_dout) begin
         next_dout = pwdata[N-1:0];
      end
   end

   // configuration, outputs and watchdog
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         filt_en    <= {N{1'b0}};
         filt_half  <= `FILT_HALF_RST;
         rise_en    <= {N{1'b0}};
         fall_en    <= {N{1'b0}};
         powerup    <= `POWERUP_RST;
         safe_val   <= {N{1'b0}};
         wd_timeout <= `WD_TIMEOUT_RST;
         wd_cnt     <= `WD_TIMEOUT_RST;
         wd_arm     <= 1'b0;
         wd_expired <= 1'b0;
         dout       <= `POWERUP_RST;
      end else begin
         if (wr_filt_en) begin
            filt_en <= pwdata[N-1:0];
         end
         if (wr_filt_half && pwdata != 32'h00000000) begin
            filt_half <= pwdata;
         end
         if (wr_rise) begin
            rise_en <= pwdata[N-1:0];
         end
         if (wr_fall) begin
            fall_en <= pwdata[N-1:0];
         end
         if (wr_pwr) begin
            powerup <= pwdata[N-1:0];
         end
         if (wr_safe) begin
            safe_val <= pwdata[N-1:0];
         end
         if (wr_tmo) begin
            wd_timeout <= pwdata;
         end

         dout <= next_dout;
         if (!pwr_loaded) begin
            dout <= powerup;
         end

         if (wr_ctrl) begin
            wd_arm <= pwdata[`CTRL_WD_ARM];
            wd_cnt <= wd_timeout;
         end else if (refresh && wd_arm && !wd_expired) begin
            wd_cnt <= wd_timeout;
         end else if (wd_arm && tick && !wd_expired) begin
            if (wd_cnt <= 32'h00000001) begin
               wd_cnt     <= 32'h00000000;
               wd_expired <= 1'b1;
               dout       <= safe_val;
            end else begin
               wd_cnt <= wd_cnt - 32'h00000001;
            end
         end

         if (disarm) begin
            wd_expired <= 1'b0;
         end
      end
   end

   // first cycle after reset marker
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwr_loaded <= 1'b0;
      end else begin
         pwr_loaded <= 1'b1;
      end
   end

   // read mux
   always @* begin
      rdata = 32'h00000000;
      case (paddr)
         `CTRL_OFF:       rdata[0] = wd_arm;
         `FILT_EN_OFF:    rdata[N-1:0] = filt_en;
         `FILT_HALF_OFF:  rdata = filt_half;
         `RISE_EN_OFF:    rdata[N-1:0] = rise_en;
         `FALL_EN_OFF:    rdata[N-1:0] = fall_en;
         `STATUS_OFF:     rdata[2:0] = {wd_expired, overflow, change_irq};
         `DIN_OFF:        rdata[N-1:0] = din_shown;
         `DOUT_OFF:       rdata[N-1:0] = dout;
         `POWERUP_OFF:    rdata[N-1:0] = powerup;
         `SAFE_OFF:       rdata[N-1:0] = safe_val;
         `WD_TIMEOUT_OFF: rdata = wd_timeout;
         `CMD_OFF:        rdata = 32'h00000000;
         default:         rdata = 32'h00000000;
      endcase
   end

   // apb answer, no wait state
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & (paddr > `CMD_OFF | paddr[1:0] != 2'b00);

         if (psel && !penable && !pwrite) begin
            prdata <= rdata;
         end else if (rd) begin
            prdata <= 32'h00000000;
         end
      end
   end

endmodule // dio_cond
`default_nettype wire

// ---- bench/dio_cond_props.sv ----
// assertions on the apb side and the output pins of dio_cond
// assumes binding into dio_cond and the register header on the include path
`timescale 1ns/100ps
`default_nettype none
`include "dio_cond_regs.vh"
module dio_cond_props #(
   parameter N = 8
) (
   input wire logic         pclk,
   input wire logic         presetn,
   input wire logic         psel,
   input wire logic         penable,
   input wire logic         pwrite,
   input wire logic [11:0]  paddr,
   input wire logic [31:0]  pwdata,
   input wire logic [31:0]  prdata,
   input wire logic         pready,
   input wire logic         pslverr,
   input wire logic [N-1:0] din,
   input wire logic [N-1:0] dout,
   input wire logic         change_irq,
   input wire logic         wd_expired
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire acc_w  = psel && penable && pwrite;
   wire disarm = acc_w && paddr == `CTRL_OFF && !pwdata[`CTRL_WD_ARM];
   wire dout_w = acc_w && paddr == `DOUT_OFF;
   wire serv   = acc_w && paddr == `CMD_OFF && pwdata[`CMD_SERVICE];
   ready_next_a: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   ready_acc_a: assert property (pready |-> psel && penable)
      else $error("ready outside access");
   unmapped_err_a: assert property (psel && !penable && paddr > 12'h02c |=> pslverr)
      else $error("no error on unmapped");
   reset_low_a: assert property ($rose(presetn) |-> dout == 0 && !wd_expired && !change_irq)
      else $error("outputs not low after reset");
   expiry_hold_a: assert property (wd_expired && !disarm |=> wd_expired)
      else $error("expiry dropped early");
   disarm_clear_a: assert property (disarm |=> !wd_expired)
      else $error("expiry kept after disarm");
   write_ignored_a: assert property (wd_expired && dout_w |=> $stable(dout))
      else $error("output write taken while expired");
   dout_cause_a: assert property (!$stable(dout) |-> $past(dout_w) || wd_expired)
      else $error("outputs changed without cause");
   irq_sticky_a: assert property (change_irq && !serv |=> change_irq)
      else $error("change flag lost");
   cover property ($rose(change_irq));
   cover property ($rose(wd_expired));
   cover property (pready && pslverr);
endmodule // dio_cond_props
bind dio_cond dio_cond_props #(.N(N)) i_props (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .din(din), .dout(dout), .change_irq(change_irq),
   .wd_expired(wd_expired));
`default_nettype wire

// ---- bench/apb_host.sv ----
// host side model: apb master issuing register transfers
// assumes a slave answering with pready on pclk
`timescale 1ns/100ps
`default_nettype none
module apb_host (
   input  wire logic        pclk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [11:0]      paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   logic err;
   initial begin
      psel = 0;
      penable = 0;
      pwrite = 0;
      paddr = 0;
      pwdata = 0;
      err = 0;
   end
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
endmodule // apb_host
`default_nettype wire

// ---- bench/testbench.sv ----
// self-checking bench for dio_cond
// assumes a tick of 4 pclk cycles
`timescale 1ns/100ps
`default_nettype none
`include "dio_cond_regs.vh"
module testbench;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, change_irq, wd_expired;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [7:0]  din, dout;
   int          bad_count, check_count;
   dio_cond #(.N(8), .TICK_COUNT(16'h0004)) i_dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .din(din), .dout(dout),
      .change_irq(change_irq), .wd_expired(wd_expired));
   apb_host i_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   task stop_test;
      if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      i_host.xfer(1'b1, a, d, q);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] e);
      i_host.xfer(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask
   task ticks(input int n);
      repeat (n * 4) @(posedge pclk);
   endtask
   // outputs settle after the nba region of the write edge
   task settle;
      @(negedge pclk);
   endtask
   task t_reset;
      chk(dout, 32'h00);
      rd(`POWERUP_OFF, 32'h00);
      rd(`FILT_HALF_OFF, 32'h02);
      rd(`WD_TIMEOUT_OFF, 32'hffffffff);
      wr(`POWERUP_OFF, 32'ha5);
      rd(`POWERUP_OFF, 32'ha5);
      rd(12'h030, 32'h0);
      chk(i_host.err, 32'h1);
   endtask
   task t_edge;
      wr(`RISE_EN_OFF, 32'h01);
      wr(`FALL_EN_OFF, 32'h02);
      @(posedge pclk) din <= 8'h02;
      ticks(4);
      chk(change_irq, 32'h0);
      rd(`DIN_OFF, 32'h00);
      @(posedge pclk) din <= 8'h03;
      ticks(4);
      chk(change_irq, 32'h1);
      rd(`DIN_OFF, 32'h03);
      @(posedge pclk) din <= 8'h01;
      ticks(4);
      rd(`STATUS_OFF, 32'h03);
      wr(`CMD_OFF, 32'h02);
      rd(`STATUS_OFF, 32'h00);
      wr(`RISE_EN_OFF, 32'h00);
      wr(`FALL_EN_OFF, 32'h00);
   endtask
   task t_filter;
      wr(`FILT_EN_OFF, 32'h04);
      wr(`FILT_HALF_OFF, 32'h03);
      wr(`FILT_HALF_OFF, 32'h00);
      rd(`FILT_HALF_OFF, 32'h03);
      @(posedge pclk) din <= 8'h05;
      ticks(1);
      din <= 8'h01;
      ticks(8);
      rd(`DIN_OFF, 32'h01);
      @(posedge pclk) din <= 8'h05;
      ticks(14);
      rd(`DIN_OFF, 32'h05);
      @(posedge pclk) din <= 8'h01;
      ticks(14);
      rd(`DIN_OFF, 32'h01);
   endtask
   task t_wd;
      wr(`SAFE_OFF, 32'h5a);
      wr(`DOUT_OFF, 32'h0f);
      settle;
      chk(dout, 32'h0f);
      wr(`WD_TIMEOUT_OFF, 32'h06);
      wr(`CTRL_OFF, 32'h01);
      repeat (4) begin
         ticks(3);
         wr(`CMD_OFF, 32'h01);
      end
      settle;
      chk(wd_expired, 32'h0);
      ticks(10);
      settle;
      chk(wd_expired, 32'h1);
      chk(dout, 32'h5a);
      wr(`DOUT_OFF, 32'hff);
      settle;
      chk(dout, 32'h5a);
      wr(`CTRL_OFF, 32'h00);
      settle;
      chk(wd_expired, 32'h0);
      wr(`DOUT_OFF, 32'h3c);
      settle;
      chk(dout, 32'h3c);
   endtask
   initial begin
      pclk = 0;
      forever #10 pclk = ~pclk;
   end
   initial begin
      repeat (5000) @(posedge pclk);
      bad_count++;
      stop_test;
   end
   initial begin
      presetn = 0;
      din = 0;
      repeat (4) @(posedge pclk);
      presetn <= 1;
      t_reset;
      t_edge;
      t_filter;
      t_wd;
      stop_test;
   end
endmodule // testbench
`default_nettype wire
